// >>> byte_fifo.v
`timescale 1ns/100ps
// ********************************************
// small synchronous fifo, first word fall through
// ********************************************
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  // extra pointer bit tells full from empty
  assign full        = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign empty       = (wr_ptr == rd_ptr);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  assign push        = in_valid_i & ~full;
  assign pop         = out_ready_i & ~empty;

  // storage, no reset needed since empty masks it
  always @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  // pointers
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // byte_fifo

// >>> param_cmd_defs.vh
`ifndef PARAM_CMD_DEFS_VH
`define PARAM_CMD_DEFS_VH
// ********************************************
// framing
// ********************************************
`define FRAME_DELIM      8'h7E
`define CSUM_GOOD        8'hFF
`define TYPE_LOCAL       8'h08
`define TYPE_QUEUED      8'h09
`define TYPE_LOCAL_RSP   8'h88
`define TYPE_REMOTE_REQ  8'h17
`define TYPE_REMOTE_RSP  8'h97
// ********************************************
// frame data offsets (0 = frame type byte)
// ********************************************
`define OFS_ID           16'h0001
`define OFS_L_CMD_HI     16'h0002
`define OFS_L_CMD_LO     16'h0003
`define OFS_L_PARAM      16'h0004
`define OFS_R_DEST_LAST  16'h0009
`define OFS_R_D16_HI     16'h000A
`define OFS_R_D16_LO     16'h000B
`define OFS_R_OPTS       16'h000C
`define OFS_R_CMD_HI     16'h000D
`define OFS_R_CMD_LO     16'h000E
`define OFS_R_PARAM      16'h000F
`define LOCAL_RSP_HDR    8'h05
`define REMOTE_RSP_HDR   8'h0F
// ********************************************
// status codes and options
// ********************************************
`define ST_OK            8'h00
`define ST_ERROR         8'h01
`define ST_BAD_CMD       8'h02
`define ST_BAD_PARAM     8'h03
`define ADDR16_USE64     16'hFFFE
`define OPT_APPLY        8'h02
`define MAX_PARAM_BYTES  3'h4
// ********************************************
// command names (two ascii characters)
// ********************************************
`define CMD_DEST_LOW     16'h444C
`define CMD_API_SEL      16'h4150
`define CMD_OWN_ADDR     16'h4D59
`define CMD_CHANNEL      16'h4348
`define CMD_APPLY        16'h4143
`define CMD_NET_DISC     16'h4E44
`define CMD_ACT_SCAN     16'h4153
// ********************************************
// parameter reset values and limits
// ********************************************
`define RST_DEST_LOW     32'h00000000
`define RST_API_SEL      32'h00000001
`define RST_OWN_ADDR     32'h00000000
`define RST_CHANNEL      32'h0000000C
`define API_SEL_MAX      32'h00000002
`define FIFO_DEPTH       8
`define FIFO_WIDTH       8
`endif

// >>> param_command_frame_handler.v
`timescale 1ns/100ps
`include "param_cmd_defs.vh"
module param_command_frame_handler (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire [7:0]  rx_data_i,
  input  wire        rx_valid_i,
  output wire        rx_ready_o,
  output wire [7:0]  tx_data_o,
  output wire        tx_valid_o,
  input  wire        tx_ready_i,
  output reg         rmt_req_valid_o,
  output reg  [7:0]  rmt_req_id_o,
  output reg  [63:0] rmt_req_dest64_o,
  output reg  [15:0] rmt_req_dest16_o,
  output reg         rmt_req_use64_o,
  output reg         rmt_req_apply_o,
  output reg  [15:0] rmt_req_cmd_o,
  output reg  [31:0] rmt_req_data_o,
  output reg  [2:0]  rmt_req_len_o,
  input  wire        rmt_ans_valid_i,
  output wire        rmt_ans_ready_o,
  input  wire [7:0]  rmt_ans_id_i,
  input  wire [63:0] rmt_ans_src64_i,
  input  wire [15:0] rmt_ans_src16_i,
  input  wire [15:0] rmt_ans_cmd_i,
  input  wire [7:0]  rmt_ans_status_i,
  input  wire [31:0] rmt_ans_data_i,
  input  wire [2:0]  rmt_ans_len_i,
  output wire [31:0] dest_addr_low_param_o,
  output wire [1:0]  api_framing_select_o
);
  // ********************************************
  // states
  // ********************************************
  localparam [10:0] S_HUNT  = 11'h001;
  localparam [10:0] S_LENH  = 11'h002;
  localparam [10:0] S_LENL  = 11'h004;
  localparam [10:0] S_DATA  = 11'h008;
  localparam [10:0] S_CSUM  = 11'h010;
  localparam [10:0] S_EXEC  = 11'h020;
  localparam [10:0] S_RDWT  = 11'h040;
  localparam [10:0] S_APRD  = 11'h080;
  localparam [10:0] S_APWR  = 11'h100;
  localparam [10:0] S_RESP  = 11'h200;
  localparam [10:0] S_SEND  = 11'h400;

  reg  [10:0]  state;
  reg  [15:0]  rx_len;
  reg  [15:0]  idx;
  reg  [7:0]   rx_sum;
  reg  [7:0]   ftype;
  reg  [7:0]   fid;
  reg  [15:0]  cmd;
  reg  [31:0]  par;
  reg  [2:0]   plen;
  reg          over;
  reg  [63:0]  dest64;
  reg  [15:0]  dest16;
  reg  [7:0]   opts;
  reg  [3:0]   dirty;
  reg  [3:0]   set_f;
  reg  [1:0]   ap_i;
  reg          do_apply;
  reg  [1:0]   slot;
  reg  [7:0]   status;
  reg  [31:0]  rdat;
  reg  [2:0]   rlen;
  reg          remote;
  reg  [63:0]  src64;
  reg  [15:0]  src16;
  reg  [151:0] rsp_buf;
  reg  [7:0]   tx_len;
  reg  [7:0]   tx_j;
  reg  [7:0]   tx_sum;
  reg  [7:0]   tx_byte;
  reg  [31:0]  dflt;
  reg          mem_we;
  reg  [2:0]   mem_wa;
  reg  [31:0]  mem_wd;
  reg  [2:0]   mem_ra;
  reg  [31:0]  api_val;
  reg  [31:0]  dest_val;
  wire [31:0]  mem_rd;
  wire         fifo_ready;
  wire         rx_take;
  wire         ans_take;
  wire [7:0]   sum_next;
  wire         is_slot;
  wire [2:0]   width;
  wire         last_ap;

  // ********************************************
  // command decode
  // ********************************************
  // the slot index and byte width of each stored parameter
  assign is_slot = (cmd == `CMD_DEST_LOW) || (cmd == `CMD_API_SEL) ||
                   (cmd == `CMD_OWN_ADDR) || (cmd == `CMD_CHANNEL);
  assign width   = (cmd == `CMD_DEST_LOW) ? 3'h4 :
                   (cmd == `CMD_OWN_ADDR) ? 3'h2 : 3'h1;
  always @* begin
    case (cmd)
      `CMD_DEST_LOW: slot = 2'h0;
      `CMD_API_SEL:  slot = 2'h1;
      `CMD_OWN_ADDR: slot = 2'h2;
      default:       slot = 2'h3;
    endcase
    case (slot)
      2'h0:    dflt = `RST_DEST_LOW;
      2'h1:    dflt = `RST_API_SEL;
      2'h2:    dflt = `RST_OWN_ADDR;
      default: dflt = `RST_CHANNEL;
    endcase
  end

  // a pending remote answer wins over a new frame in hunt
  assign rx_take  = rx_valid_i & rx_ready_o;
  assign ans_take = rmt_ans_valid_i & rmt_ans_ready_o;
  assign rmt_ans_ready_o = state[0];
  assign rx_ready_o = (state[0] & ~rmt_ans_valid_i) | state[1] | state[2] |
                      state[3] | state[4];
  assign sum_next = rx_sum + rx_data_i;
  assign last_ap  = (ap_i == 2'h3);

  // ********************************************
  // parameter store access
  // ********************************************
  // immediate writes to the active half, queued to the upper
  always @* begin
    mem_we = 1'b0;
    mem_wa = 3'h0;
    mem_wd = par;
    mem_ra = {1'b1, ap_i};
    if (state[5] && is_slot && plen != 3'h0 && !over && plen <= width &&
        !(slot == 2'h1 && par > `API_SEL_MAX)) begin
      mem_we = 1'b1;
      mem_wa = {(ftype == `TYPE_QUEUED), slot};
    end else if (state[8]) begin
      mem_we = 1'b1;
      mem_wa = {1'b0, ap_i};
      mem_wd = mem_rd;
    end
    if (state[5]) begin
      mem_ra = {1'b0, slot};
    end
  end

  param_mem u_mem (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (mem_we),
    .wr_addr_i (mem_wa),
    .wr_data_i (mem_wd),
    .rd_addr_i (mem_ra),
    .rd_data_o (mem_rd)
  );

  // active copies of two system parameters
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      api_val  <= `RST_API_SEL;
      dest_val <= `RST_DEST_LOW;
    end else if (mem_we && mem_wa == 3'h1) begin
      api_val  <= mem_wd;
    end else if (mem_we && mem_wa == 3'h0) begin
      dest_val <= mem_wd;
    end
  end
  assign api_framing_select_o  = api_val[1:0];
  assign dest_addr_low_param_o = dest_val;

  // ********************************************
  // outgoing frame bytes
  // ********************************************
  always @* begin
    if (tx_j == 8'h00) begin
      tx_byte = `FRAME_DELIM;
    end else if (tx_j == 8'h01) begin
      tx_byte = 8'h00;
    end else if (tx_j == 8'h02) begin
      tx_byte = tx_len;
    end else if (tx_j == tx_len + 8'h03) begin
      tx_byte = `CSUM_GOOD - tx_sum;
    end else begin
      tx_byte = rsp_buf[151:144];
    end
  end

  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_data_i   (tx_byte),
    .in_valid_i  (state[10]),
    .in_ready_o  (fifo_ready),
    .out_data_o  (tx_data_o),
    .out_valid_o (tx_valid_o),
    .out_ready_i (tx_ready_i)
  );

  // ********************************************
  // main sequencer
  // ********************************************
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state    <= S_HUNT;
      rx_len   <= 16'h0000;
      idx      <= 16'h0000;
      rx_sum   <= 8'h00;
      ftype    <= 8'h00;
      fid      <= 8'h00;
      cmd      <= 16'h0000;
      par      <= 32'h0;
      plen     <= 3'h0;
      over     <= 1'b0;
      dest64   <= 64'h0;
      dest16   <= 16'h0000;
      opts     <= 8'h00;
      dirty    <= 4'h0;
      set_f    <= 4'h0;
      ap_i     <= 2'h0;
      do_apply <= 1'b0;
      status   <= 8'h00;
      rdat     <= 32'h0;
      rlen     <= 3'h0;
      remote   <= 1'b0;
      src64    <= 64'h0;
      src16    <= 16'h0000;
      rsp_buf  <= 152'h0;
      tx_len   <= 8'h00;
      tx_j     <= 8'h00;
      tx_sum   <= 8'h00;
      rmt_req_valid_o  <= 1'b0;
      rmt_req_id_o     <= 8'h00;
      rmt_req_dest64_o <= 64'h0;
      rmt_req_dest16_o <= 16'h0000;
      rmt_req_use64_o  <= 1'b0;
      rmt_req_apply_o  <= 1'b0;
      rmt_req_cmd_o    <= 16'h0000;
      rmt_req_data_o   <= 32'h0;
      rmt_req_len_o    <= 3'h0;
    end else begin
      rmt_req_valid_o <= 1'b0;
      case (state)
        S_HUNT: begin
          // bytes before a delimiter are dropped
          if (ans_take) begin
            remote <= 1'b1;
            fid    <= rmt_ans_id_i;
            src64  <= rmt_ans_src64_i;
            src16  <= rmt_ans_src16_i;
            cmd    <= rmt_ans_cmd_i;
            status <= rmt_ans_status_i;
            rdat   <= rmt_ans_data_i;
            rlen   <= rmt_ans_len_i;
            state  <= S_RESP;
          end else if (rx_take && rx_data_i == `FRAME_DELIM) begin
            state <= S_LENH;
          end
        end
        S_LENH: begin
          if (rx_take) begin
            rx_len[15:8] <= rx_data_i;
            state        <= S_LENL;
          end
        end
        S_LENL: begin
          if (rx_take) begin
            rx_len[7:0] <= rx_data_i;
            idx    <= 16'h0000;
            rx_sum <= 8'h00;
            plen   <= 3'h0;
            over   <= 1'b0;
            par    <= 32'h00000000;
            // empty frame has no type: hunt again
            state  <= ({rx_len[15:8], rx_data_i} == 16'h0000) ? S_HUNT : S_DATA;
          end
        end
        S_DATA: begin
          if (rx_take) begin
            rx_sum <= sum_next;
            idx    <= idx + 16'h0001;
            if (idx == 16'h0000) begin
              ftype <= rx_data_i;
            end else if (idx == `OFS_ID) begin
              fid <= rx_data_i;
            end else if (ftype == `TYPE_REMOTE_REQ) begin
              if (idx <= `OFS_R_DEST_LAST) begin
                dest64 <= {dest64[55:0], rx_data_i};
              end else if (idx == `OFS_R_D16_HI) begin
                dest16[15:8] <= rx_data_i;
              end else if (idx == `OFS_R_D16_LO) begin
                dest16[7:0] <= rx_data_i;
              end else if (idx == `OFS_R_OPTS) begin
                opts <= rx_data_i;
              end else if (idx == `OFS_R_CMD_HI) begin
                cmd[15:8] <= rx_data_i;
              end else if (idx == `OFS_R_CMD_LO) begin
                cmd[7:0] <= rx_data_i;
              end else begin
                par  <= {par[23:0], rx_data_i};
                plen <= (plen == `MAX_PARAM_BYTES) ? plen : plen + 3'h1;
                over <= over | (plen == `MAX_PARAM_BYTES);
              end
            end else if (idx == `OFS_L_CMD_HI) begin
              cmd[15:8] <= rx_data_i;
            end else if (idx == `OFS_L_CMD_LO) begin
              cmd[7:0] <= rx_data_i;
            end else begin
              // over four bytes is flagged; par keeps only the last four
              par  <= {par[23:0], rx_data_i};
              plen <= (plen == `MAX_PARAM_BYTES) ? plen : plen + 3'h1;
              over <= over | (plen == `MAX_PARAM_BYTES);
            end
            if (idx + 16'h0001 == rx_len) begin
              state <= S_CSUM;
            end
          end
        end
        S_CSUM: begin
          if (rx_take) begin
            state  <= S_HUNT;
            remote <= 1'b0;
            rlen   <= 3'h0;
            status <= `ST_OK;
            if (sum_next != `CSUM_GOOD) begin
              state <= S_HUNT;
            end else if (ftype == `TYPE_LOCAL || ftype == `TYPE_QUEUED) begin
              state <= S_EXEC;
            end else if (ftype == `TYPE_REMOTE_REQ) begin
              // unknown option bits: not forwarded
              if ((opts & ~`OPT_APPLY) == 8'h00) begin
                rmt_req_valid_o  <= 1'b1;
                rmt_req_id_o     <= fid;
                rmt_req_dest64_o <= dest64;
                rmt_req_dest16_o <= dest16;
                rmt_req_use64_o  <= (dest16 == `ADDR16_USE64);
                rmt_req_apply_o  <= (opts & `OPT_APPLY) != 8'h00;
                rmt_req_cmd_o    <= cmd;
                rmt_req_data_o   <= par;
                rmt_req_len_o    <= plen;
              end
            end else begin
              state <= S_HUNT;
            end
          end
        end
        S_EXEC: begin
          ap_i     <= 2'h0;
          do_apply <= (ftype == `TYPE_LOCAL);
          state    <= (ftype == `TYPE_LOCAL) ? S_APRD : S_RESP;
          if (is_slot) begin
            if (plen == 3'h0) begin
              state <= S_RDWT;
            end else if (over || plen > width ||
                         (slot == 2'h1 && par > `API_SEL_MAX)) begin
              status <= `ST_BAD_PARAM;
            end else if (ftype == `TYPE_QUEUED) begin
              dirty[slot] <= 1'b1;
            end else begin
              // fresh value beats an older queued one
              dirty[slot] <= 1'b0;
              set_f[slot] <= 1'b1;
            end
          end else if (cmd == `CMD_APPLY) begin
            if (plen != 3'h0) begin
              status <= `ST_ERROR;
            end else begin
              state <= S_APRD;
            end
          end else if (cmd == `CMD_NET_DISC || cmd == `CMD_ACT_SCAN) begin
            // no neighbours: only the closing empty ok
            status <= (plen != 3'h0) ? `ST_ERROR : `ST_OK;
          end else begin
            status <= `ST_BAD_CMD;
          end
        end
        S_RDWT: begin
          // unwritten slots answer their reset value
          rdat  <= set_f[slot] ? mem_rd : dflt;
          rlen  <= width;
          state <= do_apply ? S_APRD : S_RESP;
        end
        S_APRD: begin
          if (dirty[ap_i]) begin
            state <= S_APWR;
          end else if (last_ap) begin
            state <= S_RESP;
          end else begin
            ap_i <= ap_i + 2'h1;
          end
        end
        S_APWR: begin
          dirty[ap_i] <= 1'b0;
          set_f[ap_i] <= 1'b1;
          ap_i        <= ap_i + 2'h1;
          state       <= last_ap ? S_RESP : S_APRD;
        end
        S_RESP: begin
          // payload left-justified, first byte leaves first
          tx_j   <= 8'h00;
          tx_sum <= 8'h00;
          if (remote) begin
            tx_len  <= `REMOTE_RSP_HDR + {5'h00, rlen};
            rsp_buf <= {`TYPE_REMOTE_RSP, fid, src64, src16, cmd, status,
                        rdat << {(3'h4 - rlen), 3'h0}};
          end else begin
            tx_len  <= `LOCAL_RSP_HDR + {5'h00, rlen};
            rsp_buf <= {`TYPE_LOCAL_RSP, fid, cmd, status,
                        rdat << {(3'h4 - rlen), 3'h0}, 80'h0};
          end
          state <= (fid == 8'h00) ? S_HUNT : S_SEND;
        end
        S_SEND: begin
          // stalls while the output fifo is full
          if (fifo_ready) begin
            tx_j <= tx_j + 8'h01;
            if (tx_j >= 8'h03 && tx_j != tx_len + 8'h03) begin
              tx_sum  <= tx_sum + tx_byte;
              rsp_buf <= {rsp_buf[143:0], 8'h00};
            end
            if (tx_j == tx_len + 8'h03) begin
              state <= S_HUNT;
            end
          end
        end
        default: begin
          state <= S_HUNT;
        end
      endcase
    end
  end
endmodule // param_command_frame_handler

// >>> param_command_frame_handler_props.sv
`timescale 1ns/100ps
// ********************
// port checker
// ********************
module param_command_frame_handler_props (
  input wire        sys_clk_i,
  input wire        rst_i,
  input wire        rx_ready_o,
  input wire [7:0]  tx_data_o,
  input wire        tx_valid_o,
  input wire        tx_ready_i,
  input wire        rmt_req_valid_o,
  input wire [15:0] rmt_req_dest16_o,
  input wire        rmt_req_use64_o,
  input wire [2:0]  rmt_req_len_o,
  input wire        rmt_ans_valid_i,
  input wire        rmt_ans_ready_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire       take = tx_valid_o && tx_ready_i;
  reg [15:0] pos;
  reg [15:0] len;
  reg [7:0]  sum;
  // frame byte position; sum from type byte
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      pos <= 16'h0000;
      len <= 16'h0000;
      sum <= 8'h00;
    end else if (take) begin
      pos <= (pos > 16'h0003 && pos == len + 16'h0003) ? 16'h0000 : pos + 16'h0001;
      if (pos == 16'h0001) len[15:8] <= tx_data_o;
      if (pos == 16'h0002) len[7:0] <= tx_data_o;
      sum <= (pos < 16'h0003) ? 8'h00 : sum + tx_data_o;
    end
  end
  reset_idle_a: assert property (
    $fell(rst_i) |-> rx_ready_o && !tx_valid_o && !rmt_req_valid_o)
    else $error("not idle after reset");
  start_delim_a: assert property (
    take && pos == 16'h0000 |-> tx_data_o == 8'h7E)
    else $error("frame lacks delimiter");
  rsp_type_a: assert property (
    take && pos == 16'h0003 |-> tx_data_o == 8'h88 || tx_data_o == 8'h97)
    else $error("unexpected frame type");
  csum_ok_a: assert property (
    take && pos > 16'h0003 && pos == len + 16'h0003 |-> sum + tx_data_o == 8'hFF)
    else $error("bad checksum sent");
  tx_hold_a: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("byte lost while stalled");
  req_pulse_a: assert property (
    rmt_req_valid_o |=> !rmt_req_valid_o)
    else $error("request longer than one cycle");
  use64_sel_a: assert property (
    rmt_req_valid_o |-> rmt_req_use64_o == (rmt_req_dest16_o == 16'hFFFE))
    else $error("address mode wrong");
  req_len_a: assert property (
    rmt_req_valid_o |-> rmt_req_len_o <= 3'h4)
    else $error("parameter count too big");
  ans_block_a: assert property (
    rmt_ans_valid_i && rmt_ans_ready_o |-> !rx_ready_o)
    else $error("host byte taken with answer pending");
endmodule // param_command_frame_handler_props

// >>> param_command_frame_handler_tb.sv
`timescale 1ns/100ps
module param_command_frame_handler_tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  rxd = 8'h00;
  reg         rxv = 1'b0;
  reg         txr = 1'b0;
  wire        rxr, txv, rqv, u64, apl, anv, anr;
  wire [7:0]  txd, rqid, anid, anst;
  wire [63:0] rq64, an64;
  wire [15:0] rq16, rqc, an16, anc;
  wire [31:0] rqd, and_, dlow;
  wire [2:0]  rql, anl;
  wire [1:0]  api;
  integer     n_mismatch = 0;
  integer     n_compared = 0;
  reg  [7:0]  fr[$];
  param_command_frame_handler u_param_command_frame_handler (
    .sys_clk_i(clk), .rst_i(rst), .rx_data_i(rxd), .rx_valid_i(rxv), .rx_ready_o(rxr),
    .tx_data_o(txd), .tx_valid_o(txv), .tx_ready_i(txr), .rmt_req_valid_o(rqv),
    .rmt_req_id_o(rqid), .rmt_req_dest64_o(rq64), .rmt_req_dest16_o(rq16),
    .rmt_req_use64_o(u64), .rmt_req_apply_o(apl), .rmt_req_cmd_o(rqc), .rmt_req_data_o(rqd),
    .rmt_req_len_o(rql), .rmt_ans_valid_i(anv), .rmt_ans_ready_o(anr), .rmt_ans_id_i(anid),
    .rmt_ans_src64_i(an64), .rmt_ans_src16_i(an16), .rmt_ans_cmd_i(anc),
    .rmt_ans_status_i(anst), .rmt_ans_data_i(and_), .rmt_ans_len_i(anl),
    .dest_addr_low_param_o(dlow), .api_framing_select_o(api));
  remote_node_model u_remote_node_model (
    .sys_clk_i(clk), .rst_i(rst), .req_valid_i(rqv), .req_id_i(rqid), .req_dest64_i(rq64),
    .req_cmd_i(rqc), .req_len_i(rql), .ans_ready_i(anr), .ans_valid_o(anv), .ans_id_o(anid),
    .ans_src64_o(an64), .ans_src16_o(an16), .ans_cmd_o(anc), .ans_status_o(anst),
    .ans_data_o(and_), .ans_len_o(anl));
  // 100 ns period
  always #50 clk = ~clk;
  task stop_test;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task check(input [8*8:1] what, input [63:0] exp, input [63:0] act);
    begin
      n_compared = n_compared + 1;
      if (act !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %0s exp %h got %h", what, exp, act);
      end
    end
  endtask
  task step;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task guard(input integer k);
    if (k >= 300) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED handshake exp done got timeout");
      stop_test;
    end
  endtask
  // frame n payload bytes, top first; bad spoils sum
  task mk(input [255:0] p, input integer n, input bad);
    integer i;
    reg [7:0] s;
    begin
      s = 8'hFF;
      fr = {8'h7E, 8'h00, n[7:0]};
      for (i = n - 1; i >= 0; i = i - 1) begin
        fr.push_back(p[8*i +: 8]);
        s = s - p[8*i +: 8];
      end
      fr.push_back(s ^ {7'h00, bad});
    end
  endtask
  // send a frame, take reply stalling each byte
  task xact(input [255:0] rq, input integer nq, input [255:0] rs, input integer ns,
            input bad);
    integer i;
    integer k;
    begin
      mk(rq, nq, bad);
      for (i = 0; i < fr.size(); i = i + 1) begin
        rxd = fr[i];
        rxv = 1'b1;
        for (k = 0; rxr !== 1'b1 && k < 300; k = k + 1) step;
        guard(k);
        step;
      end
      rxv = 1'b0;
      mk(rs, ns, 1'b0);
      if (ns == 0) begin
        repeat (40) step;
        check("silent", 64'h0, {63'h0, txv});
      end
      for (i = 0; ns > 0 && i < fr.size(); i = i + 1) begin
        txr = 1'b0;
        step;
        txr = 1'b1;
        for (k = 0; txv !== 1'b1 && k < 300; k = k + 1) step;
        guard(k);
        check("rsp byte", {56'h0, fr[i]}, {56'h0, txd});
        step;
      end
      txr = 1'b0;
    end
  endtask
  task t_local;
    begin
      xact(32'h0801444C, 4, 72'h8801444C0000000000, 9, 0);
      xact(32'h08024150, 4, 48'h880241500001, 6, 0);
      $display("test local done");
    end
  endtask
  task t_queue;
    begin
      xact(64'h0903444C00000FFF, 8, 40'h8803444C00, 5, 0);
      xact(32'h0904444C, 4, 72'h8804444C0000000000, 9, 0);
      check("dest low", 64'h0, {32'h0, dlow});
      xact(40'h0805415002, 5, 40'h8805415000, 5, 0);
      check("dest low", 64'hFFF, {32'h0, dlow});
      check("api sel", 64'h2, {62'h0, api});
      xact(64'h0906444C00001234, 8, 40'h8806444C00, 5, 0);
      xact(32'h08074143, 4, 40'h8807414300, 5, 0);
      check("dest low", 64'h1234, {32'h0, dlow});
      $display("test queue done");
    end
  endtask
  task t_errors;
    begin
      xact(32'h0800444C, 4, 0, 0, 0);
      xact(32'h0808444C, 4, 0, 0, 1);
      xact(32'h5509444C, 4, 0, 0, 0);
      xact(32'h080A5A5A, 4, 40'h880A5A5A02, 5, 0);
      xact(40'h080B415005, 5, 40'h880B415003, 5, 0);
      check("api sel", 64'h2, {62'h0, api});
      xact(40'h080C414301, 5, 40'h880C414301, 5, 0);
      xact(32'h080D4E44, 4, 40'h880D4E4400, 5, 0);
      xact(32'h090E4153, 4, 40'h880E415300, 5, 0);
      $display("test errors done");
    end
  endtask
  task t_remote;
    begin
      xact(120'h17100013A20011223344FFFE02444C, 15,
           136'h97100013A2001122334400C3444C001A2B, 17, 0);
      check("dest64", 64'h0013A20011223344, rq64);
      check("flags", 64'h18, {59'h0, u64, apl, rql});
      check("cmd id", 64'h444C10, {40'h0, rqc, rqid});
      xact(128'h1711000000000000FFFF12340043480B, 16,
           120'h9711000000000000FFFF00C3434800, 15, 0);
      check("flags", 64'h01, {59'h0, u64, apl, rql});
      check("d16 data", 64'h12340000000B, {16'h0, rq16, rqd});
      xact(120'h17120013A20011223344FFFE03444C, 15, 0, 0, 0);
      check("cmd id", 64'h434811, {40'h0, rqc, rqid});
      $display("test remote done");
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_local;
    t_queue;
    t_errors;
    t_remote;
    stop_test;
  end
endmodule // param_command_frame_handler_tb
bind param_command_frame_handler param_command_frame_handler_props u_props (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .rmt_req_valid_o(rmt_req_valid_o),
  .rmt_req_dest16_o(rmt_req_dest16_o), .rmt_req_use64_o(rmt_req_use64_o),
  .rmt_req_len_o(rmt_req_len_o), .rmt_ans_valid_i(rmt_ans_valid_i),
  .rmt_ans_ready_o(rmt_ans_ready_o));

// >>> param_mem.v
`timescale 1ns/100ps
// ********************************************
// parameter store: low half active, high half queued
// ********************************************
module param_mem (
  input  wire        sys_clk_i,
  input  wire        wr_en_i,
  input  wire [2:0]  wr_addr_i,
  input  wire [31:0] wr_data_i,
  input  wire [2:0]  rd_addr_i,
  output reg  [31:0] rd_data_o
);
  reg [31:0] mem [0:7];

  // registered read, one cycle latency
  always @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // param_mem

// >>> remote_node_model.sv
`timescale 1ns/100ps
// ********************
// remote node model
// ********************
module remote_node_model #(
  parameter DELAY = 6
) (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        req_valid_i,
  input  wire [7:0]  req_id_i,
  input  wire [63:0] req_dest64_i,
  input  wire [15:0] req_cmd_i,
  input  wire [2:0]  req_len_i,
  input  wire        ans_ready_i,
  output reg         ans_valid_o = 1'b0,
  output reg  [7:0]  ans_id_o = 8'h00,
  output reg  [63:0] ans_src64_o = 64'h0,
  output reg  [15:0] ans_src16_o = 16'h0000,
  output reg  [15:0] ans_cmd_o = 16'h0000,
  output reg  [7:0]  ans_status_o = 8'h00,
  output reg  [31:0] ans_data_o = 32'h0,
  output reg  [2:0]  ans_len_o = 3'h0
);
  integer wait_cnt;
  // answer after DELAY, hold until taken, then invert stale fields
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      ans_valid_o <= 1'b0;
      wait_cnt <= -1;
    end else if (req_valid_i) begin
      wait_cnt <= DELAY;
      {ans_id_o, ans_src64_o, ans_cmd_o} <= {req_id_i, req_dest64_i, req_cmd_i};
      ans_src16_o <= 16'h00C3;
      ans_status_o <= 8'h00;
      ans_data_o <= (req_len_i == 3'h0) ? 32'h00001A2B : 32'h0;
      ans_len_o <= (req_len_i == 3'h0) ? 3'h2 : 3'h0;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (wait_cnt == 0) begin
      ans_valid_o <= 1'b1;
      wait_cnt <= -1;
    end else if (ans_valid_o && ans_ready_i) begin
      ans_valid_o <= 1'b0;
      {ans_id_o, ans_src64_o, ans_data_o} <= ~{ans_id_o, ans_src64_o, ans_data_o};
    end
  end
endmodule // remote_node_model
